// ### hdl/tafc_top.v
/*
  Thermal alarm and automatic fan control: limit comparison, clear-on-read
  status (diode error held until reset), alarm interrupt, open-drain overtemperature pin and the fan loop.
  Assumes new temperature samples are flagged by a one-cycle strobe from
  same-clock conversion logic, and register reads by a one-cycle strobe.
*/
`timescale 1ns/10ps
`include "tafc_consts.vh"

module tafc_top #(
  parameter SPINUP_CYC = `TAFC_SPINUP_CYC
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Temperature samples, quarter degree, signed
  input wire sample_stb,
  input wire [9:0] local_temp,
  input wire [9:0] remote_temp,
  // Limits: index 0 local, 1 remote
  input wire [19:0] low_limit,
  input wire [19:0] high_limit,
  input wire [19:0] ot_limit,
  input wire [1:0] chan_int_en,
  // Fan loop settings
  input wire [1:0] fan_mode,
  input wire [4:0] start_temp_code,
  input wire [2:0] span_code,
  input wire [3:0] min_duty,
  input wire [3:0] sw_duty,
  input wire [3:0] filt_duty,
  input wire [3:0] rpm_duty,
  input wire tach_fail,
  input wire diode_fault,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Pins
  output wire alarm_n,
  input wire overtemp_n_i,
  output wire overtemp_n_o,
  output wire overtemp_n_oe,
  output wire pwm_out
);

  reg [7:0] status1_reg;
  reg [7:0] status2_reg;
  reg [7:0] ot_behav_reg;
  reg [1:0] ot_active_reg;
  reg [1:0] ot_int_armed_reg;
  reg ot_sync1_reg;
  reg ot_sync2_reg;
  reg ot_drv_d1_reg;
  reg ot_drv_d2_reg;
  reg diode_seen_reg;
  reg alarm_spd_armed_reg;
  reg fan_on_reg;
  reg spinning_reg;
  reg [31:0] spin_cnt_reg;
  reg [3:0] duty_reg;
  reg [1:0] hi_viol;
  reg [1:0] lo_viol;
  reg [1:0] ot_over;
  reg [1:0] ot_below;
  reg [3:0] auto_duty;
  reg [3:0] duty_next;
  wire rd_s1;
  wire rd_s2;
  wire ext_pull;
  wire fan_force;
  wire overtemp_fan_force_en;
  wire signed [9:0] t_start;
  wire signed [9:0] t_ctrl;
  wire signed [11:0] t_above;
  wire [11:0] span_lsb;
  wire [15:0] duty_frac;
  wire [15:0] duty_quot;

  assign rd_s1 = reg_rd && (reg_addr == `TAFC_OFS_STATUS1);
  assign rd_s2 = reg_rd && (reg_addr == `TAFC_OFS_STATUS2);
  assign overtemp_fan_force_en = ot_behav_reg[`TAFC_OTB_FAN_FORCE];

  // Signed comparisons per channel, index 0 local and 1 remote.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
      wire signed [9:0] t = gi ? remote_temp : local_temp;
      always @* begin
        lo_viol[gi] = t < $signed(low_limit[gi*10 +: 10]);
        hi_viol[gi] = t > $signed(high_limit[gi*10 +: 10]);
        ot_over[gi] = t > $signed(ot_limit[gi*10 +: 10]);
        ot_below[gi] = t < ($signed(ot_limit[gi*10 +: 10]) - `TAFC_HYST_LSB);
      end
    end
  endgenerate

  // Two-stage synchroniser for the shared open-drain pin. Our own drive is
  // delayed by the same two stages, so the low that is still in the
  // synchroniser after we let go is not taken for an outside pull.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ot_sync1_reg <= 1'b1;
      ot_sync2_reg <= 1'b1;
      ot_drv_d1_reg <= 1'b0;
      ot_drv_d2_reg <= 1'b0;
    end else begin
      ot_sync1_reg <= overtemp_n_i;
      ot_sync2_reg <= ot_sync1_reg;
      ot_drv_d1_reg <= |ot_active_reg;
      ot_drv_d2_reg <= ot_drv_d1_reg;
    end
  end

  // Only a low we are not driving, and have not just driven, is external.
  assign ext_pull = !ot_sync2_reg && !(|ot_active_reg) &&
                    !ot_drv_d1_reg && !ot_drv_d2_reg;
  assign overtemp_n_o = 1'b0;
  assign overtemp_n_oe = |ot_active_reg;

  // Overtemperature latches hold until the temperature drops by hysteresis.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ot_active_reg <= 2'b00;
      ot_int_armed_reg <= 2'b11;
    end else if (sample_stb) begin
      ot_active_reg <= (ot_active_reg | ot_over) & ~ot_below;
      ot_int_armed_reg <= (ot_int_armed_reg & ~ot_over) | ot_below;
    end
  end

  // Register writes; the revision field is read-only.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ot_behav_reg <= `TAFC_OTB_RESET;
    end else if (reg_wr && reg_addr == `TAFC_OFS_OT_BEHAV) begin
      ot_behav_reg <= {reg_wdata[7], `TAFC_REV_CODE};
    end
  end

  // Diode error is caught after reset release, so the strap-like input
  // never feeds an asynchronously reset flop directly.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      diode_seen_reg <= 1'b0;
    end else if (!diode_seen_reg) begin
      diode_seen_reg <= 1'b1;
    end
  end

  // Status flags: a set in the cycle of a read wins over the clear.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status1_reg <= 8'h00;
      status2_reg <= 8'h00;
      alarm_spd_armed_reg <= 1'b1;
    end else begin
      if (rd_s1) begin
        status1_reg[`TAFC_S1_ALARM_SPD] <= 1'b0;
        status1_reg[`TAFC_S1_FAN_FAULT] <= 1'b0;
        status1_reg[`TAFC_S1_REM_HIGH] <= 1'b0;
        status1_reg[`TAFC_S1_REM_LOW] <= 1'b0;
        status1_reg[`TAFC_S1_REM_OT] <= 1'b0;
        status1_reg[`TAFC_S1_LOC_HIGH] <= 1'b0;
        status1_reg[`TAFC_S1_LOC_LOW] <= 1'b0;
      end
      if (rd_s2) begin
        status2_reg <= 8'h00;
      end
      // Alarm speed rearms only once the fan has left full speed.
      if (duty_reg != `TAFC_DUTY_FULL) begin
        alarm_spd_armed_reg <= 1'b1;
      end else if (alarm_spd_armed_reg) begin
        status1_reg[`TAFC_S1_ALARM_SPD] <= 1'b1;
        alarm_spd_armed_reg <= 1'b0;
      end
      if (tach_fail) begin
        status1_reg[`TAFC_S1_FAN_FAULT] <= 1'b1;
      end
      if (!diode_seen_reg && diode_fault) begin
        status1_reg[`TAFC_S1_DIODE_ERR] <= 1'b1;
      end
      if (sample_stb) begin
        if (chan_int_en[1] && hi_viol[1]) status1_reg[`TAFC_S1_REM_HIGH] <= 1'b1;
        if (chan_int_en[1] && lo_viol[1]) status1_reg[`TAFC_S1_REM_LOW] <= 1'b1;
        if (chan_int_en[1] && ot_over[1] && ot_int_armed_reg[1]) begin
          status1_reg[`TAFC_S1_REM_OT] <= 1'b1;
        end
        if (chan_int_en[0] && hi_viol[0]) status1_reg[`TAFC_S1_LOC_HIGH] <= 1'b1;
        if (chan_int_en[0] && lo_viol[0]) status1_reg[`TAFC_S1_LOC_LOW] <= 1'b1;
        if (chan_int_en[0] && ot_over[0] && ot_int_armed_reg[0]) begin
          status2_reg[`TAFC_S2_LOC_OT] <= 1'b1;
        end
      end
      if (ext_pull) begin
        status2_reg[`TAFC_S2_EXT_OT] <= 1'b1;
      end
      // Disabling a channel drops its pending flags; last so it wins.
      if (!chan_int_en[1]) begin
        status1_reg[`TAFC_S1_REM_HIGH] <= 1'b0;
        status1_reg[`TAFC_S1_REM_LOW] <= 1'b0;
        status1_reg[`TAFC_S1_REM_OT] <= 1'b0;
      end
      if (!chan_int_en[0]) begin
        status1_reg[`TAFC_S1_LOC_HIGH] <= 1'b0;
        status1_reg[`TAFC_S1_LOC_LOW] <= 1'b0;
        status2_reg[`TAFC_S2_LOC_OT] <= 1'b0;
      end
    end
  end

  // Alarm is the OR of set flags; disabled channels hold none.
  assign alarm_n = !((|status1_reg) || (|status2_reg));

  // Register reads, data from flops; unmapped offsets read zero.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `TAFC_OFS_STATUS1: reg_rdata <= status1_reg;
        `TAFC_OFS_STATUS2: reg_rdata <= status2_reg;
        `TAFC_OFS_OT_BEHAV: reg_rdata <= ot_behav_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Start temperature in 4 C steps, in quarter degrees: code * 16.
  assign t_start = $signed({1'b0, start_temp_code, 4'h0});
  // Control temperature is the hotter of the two channels.
  assign t_ctrl = ($signed(local_temp) > $signed(remote_temp)) ? local_temp : remote_temp;
  assign t_above = {{2{t_ctrl[9]}}, t_ctrl} - {{2{t_start[9]}}, t_start};
  // Span is 2^code * 2.5 C, i.e. 10 << code in quarter degrees.
  assign span_lsb = 12'd10 << span_code;
  assign duty_frac = (16'd15 - {12'h000, min_duty}) * t_above[11:0];
  // Below the span the quotient stays under 15 minus the minimum code.
  assign duty_quot = duty_frac / {4'h0, span_lsb};

  // Duty is linear from minimum at start to full at start plus span.
  always @* begin
    if (t_above[11] || t_above == 12'h000) begin
      auto_duty = min_duty;
    end else if (t_above >= $signed({1'b0, span_lsb[10:0]})) begin
      auto_duty = `TAFC_DUTY_FULL;
    end else begin
      auto_duty = min_duty + duty_quot[3:0];
    end
  end

  assign fan_force = (overtemp_fan_force_en && (|ot_active_reg)) || ext_pull;

  // Mode select and overriding forces.
  always @* begin
    case (fan_mode)
      `TAFC_MODE_AUTO: duty_next = spinning_reg ? `TAFC_DUTY_FULL :
                                   (fan_on_reg ? auto_duty : 4'h0);
      `TAFC_MODE_FILT: duty_next = filt_duty;
      `TAFC_MODE_SW: duty_next = sw_duty;
      default: duty_next = rpm_duty;
    endcase
    if (fan_force) begin
      duty_next = `TAFC_DUTY_FULL;
    end
  end

  // Fan on/off with hysteresis and spin-up timer.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fan_on_reg <= 1'b0;
      spinning_reg <= 1'b0;
      spin_cnt_reg <= 32'h0;
      duty_reg <= 4'h0;
    end else begin
      duty_reg <= duty_next;
      if (!fan_on_reg && $signed(t_ctrl) > t_start) begin
        fan_on_reg <= 1'b1;
        spinning_reg <= 1'b1;
        spin_cnt_reg <= SPINUP_CYC - 1;
      end else if (fan_on_reg && $signed(t_ctrl) < (t_start - `TAFC_HYST_LSB)) begin
        fan_on_reg <= 1'b0;
        spinning_reg <= 1'b0;
      end else if (spinning_reg) begin
        if (spin_cnt_reg == 32'h0) spinning_reg <= 1'b0;
        else spin_cnt_reg <= spin_cnt_reg - 32'h1;
      end
    end
  end

  tafc_pwm_gen u_pwm (
    .clk(clk),
    .sys_rst(sys_rst),
    .duty(duty_reg),
    .pwm_out(pwm_out)
  );

endmodule // tafc_top

// ### pkg/tafc_consts.vh
/*
  Constants for the thermal alarm and fan control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 200 MHz clock and 8-bit register access through the plain port.
*/
`ifndef TAFC_CONSTS_VH
`define TAFC_CONSTS_VH

// Register offsets.
`define TAFC_OFS_STATUS1 8'h02
`define TAFC_OFS_STATUS2 8'h03
`define TAFC_OFS_OT_BEHAV 8'h3f

// Status register 1 bit positions.
`define TAFC_S1_ALARM_SPD 0
`define TAFC_S1_FAN_FAULT 1
`define TAFC_S1_REM_HIGH 2
`define TAFC_S1_REM_LOW 3
`define TAFC_S1_REM_OT 4
`define TAFC_S1_DIODE_ERR 5
`define TAFC_S1_LOC_HIGH 6
`define TAFC_S1_LOC_LOW 7

// Status register 2 bit positions.
`define TAFC_S2_LOC_OT 6
`define TAFC_S2_EXT_OT 7

// Behaviour register: fan force enable bit and reset value.
`define TAFC_OTB_FAN_FORCE 7
// The reset value carries the revision field, so it reads the same before and
// after the first write.
`define TAFC_OTB_RESET 8'h81
// Revision code: the value is arbitrary.
`define TAFC_REV_CODE 7'h01

// Temperatures are 10-bit signed, quarter degree LSB.
`define TAFC_HYST_DEGC 5
`define TAFC_HYST_LSB 10'sd20
`define TAFC_TMIN_STEP_DEGC 4

// Operating modes.
`define TAFC_MODE_AUTO 2'd0
`define TAFC_MODE_FILT 2'd1
`define TAFC_MODE_SW 2'd2
`define TAFC_MODE_RPM 2'd3

// Duty codes: 0..15, 15 is full speed.
`define TAFC_DUTY_FULL 4'hf

// Spin-up time and its cycle count at 200 MHz.
`define TAFC_CLK_MHZ 200
`define TAFC_SPINUP_MS 2000
`define TAFC_SPINUP_CYC (`TAFC_SPINUP_MS * 1000 * `TAFC_CLK_MHZ)

`endif

// ### hdl/tafc_pwm_gen.v
/*
  PWM generator: 16-step duty code to a registered PWM output.
  Assumes one clock domain; the duty code comes from same-clock logic.
*/
`timescale 1ns/10ps
`include "tafc_consts.vh"

module tafc_pwm_gen (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Duty code and output
  input wire [3:0] duty,
  output reg pwm_out
);

  reg [3:0] phase_reg;

  // Free-running phase; full code keeps the output high all period long.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= 4'h0;
      pwm_out <= 1'b0;
    end else begin
      phase_reg <= (phase_reg == 4'he) ? 4'h0 : phase_reg + 4'h1;
      pwm_out <= (duty == `TAFC_DUTY_FULL) ? 1'b1 : (phase_reg < duty);
    end
  end

endmodule // tafc_pwm_gen

// ### test/tafc_monitor.sv
/* Port checker for the alarm and fan block.
   Assumes a bind into tafc_top, seeing only its ports. */
`timescale 1ns/10ps
module tafc_monitor (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Samples and limits
  input wire sample_stb,
  input wire [9:0] local_temp,
  input wire [9:0] remote_temp,
  input wire [19:0] low_limit,
  input wire [19:0] high_limit,
  input wire [19:0] ot_limit,
  input wire [1:0] chan_int_en,
  // Register port
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  // Pins
  input wire alarm_n,
  input wire overtemp_n_i,
  input wire overtemp_n_o,
  input wire overtemp_n_oe,
  input wire pwm_out
);
  reg [4:0] ext_cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Length of an outside pull; full duty reaches pwm_out four cycles after the pull begins.
  always @(posedge clk or posedge sys_rst)
    if (sys_rst) ext_cnt_reg <= 5'h00;
    else if (overtemp_n_i || overtemp_n_oe) ext_cnt_reg <= 5'h00;
    else if (ext_cnt_reg != 5'h1f) ext_cnt_reg <= ext_cnt_reg + 5'h01;
  // Relations between samples, pins and register reads.
  a_pin_open_drain: assert property (overtemp_n_oe |-> !overtemp_n_o)
    else $error("pin driven high");
  a_local_high: assert property (sample_stb && chan_int_en[0] &&
    $signed(local_temp) > $signed(high_limit[9:0]) |-> ##[1:2] !alarm_n)
    else $error("no high alarm");
  a_remote_low: assert property (sample_stb && chan_int_en[1] &&
    $signed(remote_temp) < $signed(low_limit[19:10]) |-> ##[1:2] !alarm_n)
    else $error("no low alarm");
  a_ot_assert: assert property (sample_stb &&
    $signed(local_temp) > $signed(ot_limit[9:0]) |-> ##[1:2] overtemp_n_oe)
    else $error("pin not pulled");
  a_ot_release: assert property (sample_stb && overtemp_n_oe &&
    $signed(local_temp) < $signed(ot_limit[9:0]) - 20 &&
    $signed(remote_temp) < $signed(ot_limit[19:10]) - 20 |-> ##[1:2] !overtemp_n_oe)
    else $error("pin held too long");
  a_oe_steady: assert property (!$past(sample_stb) && !$past(sample_stb, 2)
    |-> $stable(overtemp_n_oe)) else $error("pin moved unprompted");
  a_ext_full: assert property (ext_cnt_reg > 5'h18 |-> pwm_out)
    else $error("fan not full");
  a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h02 &&
    reg_addr != 8'h03 && reg_addr != 8'h3f |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // tafc_monitor

// ### test/tafc_fan_model.sv
/* Fan and shared pin model: pull-up on the pin, duty seen by the fan.
   Assumes the clock of the block under test. */
`timescale 1ns/10ps
module tafc_fan_model (
  // Clock and drives
  input wire clk,
  input wire pwm_out,
  input wire overtemp_n_oe,
  input wire ext_pull,
  // Pin level and measured duty
  output wire overtemp_n_i,
  output wire [3:0] duty_seen
);
  reg [14:0] hist_reg = 15'h0000;
  reg [3:0] ones;
  integer k;
  // Pull-up: any party's enable takes the pin low.
  assign overtemp_n_i = !(overtemp_n_oe || ext_pull);
  // High count over one 15-cycle period, so the phase does not matter.
  always @(posedge clk) hist_reg <= {hist_reg[13:0], pwm_out};
  always @* begin
    ones = 4'h0;
    for (k = 0; k < 15; k = k + 1) ones = ones + {3'h0, hist_reg[k]};
  end
  assign duty_seen = ones;
endmodule // tafc_fan_model

// ### test/tafc_top_tb_top.sv
/* Bench for the alarm and fan block: register reads, samples, pin, duty.
   Assumes the checker and the fan model are compiled first. */
`timescale 1ns/10ps
module tafc_top_tb_top;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg sample_stb = 1'b0, tach_fail = 1'b0, diode_fault = 1'b0, ext_pull = 1'b0;
  reg reg_wr = 1'b0, reg_rd = 1'b0;
  reg [9:0] local_temp = 10'h064, remote_temp = 10'h064;
  reg [1:0] chan_int_en = 2'h3, fan_mode = 2'h2;
  reg [4:0] start_temp_code = 5'h05;
  reg [2:0] span_code = 3'h2;
  reg [3:0] min_duty = 4'h5, sw_duty = 4'h3;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [19:0] low_limit = {10'h3d8, 10'h3d8};
  wire [19:0] high_limit = {10'h0c8, 10'h0c8};
  wire [19:0] ot_limit = {10'h140, 10'h140};
  wire [3:0] filt_duty = 4'h6, rpm_duty = 4'h9, duty_seen;
  wire [7:0] reg_rdata;
  wire alarm_n, overtemp_n_i, overtemp_n_o, overtemp_n_oe, pwm_out;
  integer n_fail = 0, num_checks = 0, cyc = 0, m;
  tafc_top #(.SPINUP_CYC(20)) DUT (.*);
  tafc_fan_model u_fan (.clk(clk), .pwm_out(pwm_out), .overtemp_n_oe(overtemp_n_oe),
    .ext_pull(ext_pull), .overtemp_n_i(overtemp_n_i), .duty_seen(duty_seen));
  always #2.5 clk = ~clk;
  // A hang is cut short; the sequence needs about 1000 cycles.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Write when w is set, else read and compare with d.
  task acc(input w, input [7:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
      if (!w) chk(reg_rdata, d);
    end
  endtask
  task smp(input [9:0] l, input [9:0] r);
    begin
      local_temp <= l;
      remote_temp <= r;
      sample_stb <= 1'b1;
      @(posedge clk);
      sample_stb <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // Waits long enough for spin-up and a period boundary before measuring.
  task duty(input [3:0] e);
    begin
      repeat (60) @(posedge clk);
      chk({4'h0, duty_seen}, {4'h0, e});
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    acc(0, 8'h3f, 8'h81);
    acc(0, 8'h02, 8'h00);
    acc(0, 8'h10, 8'h00);
    acc(1, 8'h3f, 8'h00);
    acc(0, 8'h3f, 8'h01);
    smp(10'h0d0, 10'h064);
    chk(alarm_n, 8'h00);
    acc(0, 8'h02, 8'h40);
    chk(alarm_n, 8'h01);
    smp(10'h0d0, 10'h064);
    acc(0, 8'h02, 8'h40);
    smp(10'h064, 10'h3b0);
    chk(alarm_n, 8'h00);
    acc(0, 8'h02, 8'h08);
    smp(10'h0d0, 10'h064);
    chan_int_en <= 2'h0;
    smp(10'h0d0, 10'h3b0);
    chk(alarm_n, 8'h01);
    acc(0, 8'h02, 8'h00);
    chan_int_en <= 2'h3;
    repeat (2) begin
      tach_fail <= 1'b1;
      @(posedge clk);
      tach_fail <= 1'b0;
      acc(0, 8'h02, 8'h02);
    end
    acc(0, 8'h02, 8'h00);
    smp(10'h150, 10'h064);
    chk(overtemp_n_oe, 8'h01);
    duty(4'h3);
    acc(1, 8'h3f, 8'h80);
    duty(4'hf);
    acc(0, 8'h03, 8'h40);
    acc(0, 8'h03, 8'h00);
    acc(0, 8'h02, 8'h41);
    smp(10'h150, 10'h064);
    acc(0, 8'h02, 8'h40);
    chk(alarm_n, 8'h01);
    smp(10'h12f, 10'h064);
    chk(overtemp_n_oe, 8'h01);
    smp(10'h12b, 10'h064);
    chk(overtemp_n_oe, 8'h00);
    duty(4'h3);
    smp(10'h150, 10'h064);
    duty(4'hf);
    acc(0, 8'h03, 8'h40);
    acc(0, 8'h02, 8'h41);
    smp(10'h064, 10'h064);
    acc(1, 8'h3f, 8'h00);
    ext_pull <= 1'b1;
    duty(4'hf);
    ext_pull <= 1'b0;
    duty(4'h3);
    acc(0, 8'h03, 8'h80);
    acc(0, 8'h02, 8'h01);
    smp(10'h064, 10'h150);
    acc(0, 8'h02, 8'h14);
    smp(10'h064, 10'h064);
    for (m = 1; m < 4; m = m + 1) begin
      fan_mode <= m[1:0];
      duty(m == 1 ? 4'h6 : m == 2 ? 4'h3 : 4'h9);
    end
    fan_mode <= 2'h0;
    // Both channels go 5.25 C below start first, so the loop begins switched off.
    smp(10'h03b, 10'h03b);
    duty(4'h0);
    smp(10'h051, 10'h040);
    repeat (5) @(posedge clk);
    chk(pwm_out, 8'h01);
    duty(4'h5);
    smp(10'h078, 10'h040);
    duty(4'hf);
    smp(10'h040, 10'h040);
    duty(4'h5);
    smp(10'h03b, 10'h03b);
    duty(4'h0);
    start_temp_code <= 5'h06;
    smp(10'h078, 10'h040);
    duty(4'hb);
    fan_mode <= 2'h2;
    diode_fault <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    acc(0, 8'h02, 8'h20);
    acc(0, 8'h02, 8'h20);
    tally_and_finish;
  end
endmodule // tafc_top_tb_top
bind tafc_top tafc_monitor u_mon (.*);
